// ==== hdl/port_event_consts.vh ====
// constants for the port event and link configuration register bank
// assumes apb byte addressing, 32-bit data, one register per aligned word
`ifndef PORT_EVENT_CONSTS_VH
`define PORT_EVENT_CONSTS_VH

`define OFS_EVENT_CONTROL   12'h450
`define OFS_EVENT_STATUS    12'h454
`define OFS_SERIALIZER_CTL  12'h500
`define OFS_LINK_CONFIG     12'h530
`define OFS_LINK_STATUS     12'h538
`define OFS_IRQ_STATUS      12'h600
`define OFS_IRQ_MASK        12'h604
`define OFS_ALT_FUNCTION    12'h608

`define POS_POLARITY_INVERT 0
`define POS_PORT1           1
`define POS_PORT3           3
`define POS_LOW_SWING       8
`define POS_CROSSLINK_DIS   12
`define POS_SELF_LOOP       13
`define POS_SPEED_POLICY    14
`define POS_UPCONFIG        16

`define RST_EVENT_CONTROL   4'h0
`define RST_LOW_SWING       1'b0
`define RST_SELF_LOOP       1'b0
`define RST_CROSSLINK_DIS   1'b0
`define RST_ALT_FUNCTION    1'b0
`define RST_IRQ             5'h00

`endif

// ==== hdl/port_event_lane.v ====
// one downstream port's event path: notification steering and status
// assumes port notifications arrive as levels synchronous to clk
`timescale 1ns/10ps
`default_nettype none
module port_event_lane (
  // clock and reset
  input  wire clk,
  input  wire rst_n,
  // control
  input  wire event_enable,
  // port notification request level
  input  wire notify_req,
  // results
  output wire native_notify,
  output reg  event_flag_q
);
  // status only ever rises with enable set, and clears one cycle after enable drops
  always @(posedge clk) begin
    if (!rst_n) begin
      event_flag_q <= 1'b0;
    end else begin
      event_flag_q <= event_enable & notify_req;
    end
  end

  // with the event path enabled the normal interrupt messages are held back
  assign native_notify = notify_req & ~event_enable;
endmodule // port_event_lane
`default_nettype wire

// ==== hdl/port_event_and_link_config_regs.v ====
// register bank: per-port event status, transmitter swing, link training config
// assumes an apb master on clk; link-side status inputs are synchronous to clk
//
// What this block does
// - status bits 1 to 3 read one while that port signals an event
// - an event status bit never sets unless that port's event is enabled
// - shared pin 7 carries the event only when set to its alternate function
// - enabled ports divert hot-plug, msi and pme notices to the shared event
// - shared event output active low, active high when polarity invert set
// - bit 8 selects low swing when one, full swing at reset; sticky
// - bit 13 permits a port to crosslink train against itself
// - self loop enable ignored while crosslink disable is set
// - policy bit 14 zero: auto change to gen2 after first l0 from detect
// - policy bit one: no automatic speed change, stay at gen1
// - policy bit sticky; resets one on upstream, zero on downstream ports
// - bit 16 of link status shows partner width upconfigure capability
`timescale 1ns/10ps
`default_nettype none
`include "port_event_consts.vh"
module port_event_and_link_config_regs #(
  parameter NPORTS       = 3,
  parameter IS_UPSTREAM  = 0
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // per-port notification requests and steered native notifications
  input  wire [2:0]  notify_req,
  output wire [2:0]  native_notify,
  // shared general-purpose pin 7 (oe low while driving)
  input  wire        gpio7_in,
  input  wire        gpio7_out_normal,
  input  wire        gpio7_oe_normal_n,
  output wire        gpio7_out,
  output wire        gpio7_oe_n,
  // link training
  input  wire        link_in_detect,
  input  wire        link_in_l0,
  input  wire        gen2_permissible,
  input  wire        upconfigure_capable,
  output wire        low_swing_select,
  output wire        self_loop_permit,
  output reg         speed_change_start_q,
  // interrupt
  output wire        irq
);
  // sticky registers: cleared only by rst_n, since this block sees one reset
  reg  [3:0] event_control_q;
  reg        low_swing_q;
  reg        self_loop_q;
  reg        crosslink_dis_q;
  reg        speed_policy_q;
  reg        alt_function_q;
  reg  [4:0] irq_status_q;
  reg  [4:0] irq_mask_q;
  reg        upconfig_q;
  reg        seen_detect_q;
  reg        first_l0_done_q;
  reg  [2:0] flag_prev_q;
  wire [2:0] event_flag;
  wire       event_active;
  wire       shared_event_output;
  wire       wr_en;
  wire       rd_en;
  wire       addr_hit;
  wire [4:0] irq_events;
  wire       speed_start;
  reg  [31:0] rd_data;

  // zero wait-state slave
  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign addr_hit = (paddr == `OFS_EVENT_CONTROL) | (paddr == `OFS_EVENT_STATUS) |
                    (paddr == `OFS_SERIALIZER_CTL) | (paddr == `OFS_LINK_CONFIG) |
                    (paddr == `OFS_LINK_STATUS) | (paddr == `OFS_IRQ_STATUS) |
                    (paddr == `OFS_IRQ_MASK) | (paddr == `OFS_ALT_FUNCTION);
  assign pslverr = psel & penable & ~addr_hit;

  genvar g;
  generate
    for (g = 0; g < NPORTS; g = g + 1) begin : lane
      port_event_lane u_lane (
        .clk           (clk),
        .rst_n         (rst_n),
        .event_enable  (event_control_q[g+1]),
        .notify_req    (notify_req[g]),
        .native_notify (native_notify[g]),
        .event_flag_q  (event_flag[g])
      );
    end
  endgenerate

  assign event_active = |event_flag;
  // asserted level low unless polarity inverted
  assign shared_event_output = event_control_q[`POS_POLARITY_INVERT] ? event_active : ~event_active;
  assign gpio7_out  = alt_function_q ? shared_event_output : gpio7_out_normal;
  assign gpio7_oe_n = alt_function_q ? 1'b0 : gpio7_oe_normal_n;

  assign low_swing_select = low_swing_q;
  assign self_loop_permit = self_loop_q & ~crosslink_dis_q;

  // speed change fires once on the first l0 reached through detect
  assign speed_start = link_in_l0 & seen_detect_q & ~first_l0_done_q;
  always @(posedge clk) begin
    if (!rst_n) begin
      seen_detect_q        <= 1'b0;
      first_l0_done_q      <= 1'b0;
      speed_change_start_q <= 1'b0;
      upconfig_q           <= 1'b0;
    end else begin
      upconfig_q <= upconfigure_capable;
      if (link_in_detect) begin
        seen_detect_q <= 1'b1;
      end
      if (speed_start) begin
        first_l0_done_q <= 1'b1;
      end
      speed_change_start_q <= speed_start & ~speed_policy_q & gen2_permissible;
    end
  end

  // events: rising port flags, link upconfig change, speed change start
  assign irq_events = {speed_change_start_q, upconfig_q ^ upconfigure_capable,
                       event_flag & ~flag_prev_q};

  always @(posedge clk) begin
    if (!rst_n) begin
      event_control_q <= `RST_EVENT_CONTROL;
      low_swing_q     <= `RST_LOW_SWING;
      self_loop_q     <= `RST_SELF_LOOP;
      crosslink_dis_q <= `RST_CROSSLINK_DIS;
      speed_policy_q  <= (IS_UPSTREAM != 0) ? 1'b1 : 1'b0;
      alt_function_q  <= `RST_ALT_FUNCTION;
      irq_status_q    <= `RST_IRQ;
      irq_mask_q      <= `RST_IRQ;
      flag_prev_q     <= 3'h0;
    end else begin
      flag_prev_q <= event_flag;
      // a new event in the clearing cycle survives the write-one-to-clear
      if (wr_en && paddr == `OFS_IRQ_STATUS) begin
        irq_status_q <= (irq_status_q & ~pwdata[4:0]) | irq_events;
      end else begin
        irq_status_q <= irq_status_q | irq_events;
      end
      if (wr_en) begin
        case (paddr)
          `OFS_EVENT_CONTROL: event_control_q <= pwdata[3:0];
          `OFS_SERIALIZER_CTL: low_swing_q <= pwdata[`POS_LOW_SWING];
          `OFS_LINK_CONFIG: begin
            crosslink_dis_q <= pwdata[`POS_CROSSLINK_DIS];
            self_loop_q     <= pwdata[`POS_SELF_LOOP];
            speed_policy_q  <= pwdata[`POS_SPEED_POLICY];
          end
          `OFS_IRQ_MASK: irq_mask_q <= pwdata[4:0];
          `OFS_ALT_FUNCTION: alt_function_q <= pwdata[0];
          default: ;
        endcase
      end
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // reserved positions are left zero in every read word
  always @* begin
    rd_data = 32'h00000000;
    case (paddr)
      `OFS_EVENT_CONTROL:  rd_data[3:0] = event_control_q;
      `OFS_EVENT_STATUS:   rd_data[`POS_PORT3:`POS_PORT1] = event_flag;
      `OFS_SERIALIZER_CTL: rd_data[`POS_LOW_SWING] = low_swing_q;
      `OFS_LINK_CONFIG: begin
        rd_data[`POS_CROSSLINK_DIS] = crosslink_dis_q;
        rd_data[`POS_SELF_LOOP]     = self_loop_q;
        rd_data[`POS_SPEED_POLICY]  = speed_policy_q;
      end
      `OFS_LINK_STATUS:    rd_data[`POS_UPCONFIG] = upconfig_q;
      `OFS_IRQ_STATUS:     rd_data[4:0] = irq_status_q;
      `OFS_IRQ_MASK:       rd_data[4:0] = irq_mask_q;
      `OFS_ALT_FUNCTION:   rd_data[0] = alt_function_q;
      default:             rd_data = 32'h00000000;
    endcase
  end

  // read data is registered at the setup phase so it is stable in access
  always @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_data;
    end
  end
endmodule // port_event_and_link_config_regs
`default_nettype wire

// ==== dv/port_event_checker.sv ====
// checker: bus, pin and link relations of the port event register bank
// assumes it is bound to the bank's top ports; one clock, sync reset
`timescale 1ns/10ps
`default_nettype none
module port_event_checker (
  // clock, reset, apb
  input wire        clk, rst_n, psel, penable, pwrite, pready, pslverr,
  input wire [11:0] paddr,
  input wire [31:0] pwdata, prdata,
  // ports, pin, link
  input wire [2:0]  notify_req, native_notify,
  input wire        gpio7_oe_normal_n, gpio7_oe_n, link_in_l0, gen2_permissible,
  input wire        low_swing_select, self_loop_permit, speed_change_start_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire acc = psel && penable;
  wire rdx = acc && !pwrite;
  wire map = paddr inside {12'h450, 12'h454, 12'h500, 12'h530, 12'h538, 12'h600, 12'h604, 12'h608};
  a_bus_ready: assert property (acc |-> pready) else $error("no ready in access");
  a_unmapped_err: assert property (acc && !map |-> pslverr) else $error("no error on unmapped");
  a_unmapped_zero: assert property (rdx && !map |-> prdata == 32'h0) else $error("unmapped read data");
  a_status_resv: assert property (rdx && paddr == 12'h454 |-> (prdata & 32'hfffffff1) == 32'h0)
    else $error("status reserved bits");
  a_swing_write: assert property (acc && pwrite && paddr == 12'h500 |=> low_swing_select == $past(pwdata[8]))
    else $error("swing select");
  a_self_loop: assert property (acc && pwrite && paddr == 12'h530 |=>
    self_loop_permit == ($past(pwdata[13]) && !$past(pwdata[12]))) else $error("self loop permit");
  a_native_subset: assert property ((native_notify & ~notify_req) == 3'h0) else $error("native notice");
  a_pin_alt: assert property (gpio7_oe_n != gpio7_oe_normal_n |-> !gpio7_oe_n) else $error("pin enable");
  a_speed_cause: assert property (speed_change_start_q |-> $past(link_in_l0 && gen2_permissible))
    else $error("speed start cause");
  a_speed_single: assert property (speed_change_start_q |=> !speed_change_start_q) else $error("speed pulse");
  cover property (speed_change_start_q);
  cover property (acc && pslverr);
  cover property (!gpio7_oe_n && gpio7_oe_normal_n);
endmodule // port_event_checker
bind port_event_and_link_config_regs port_event_checker u_chk (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .notify_req(notify_req), .native_notify(native_notify), .gpio7_oe_normal_n(gpio7_oe_normal_n),
  .gpio7_oe_n(gpio7_oe_n), .link_in_l0(link_in_l0), .gen2_permissible(gen2_permissible),
  .low_swing_select(low_swing_select), .self_loop_permit(self_loop_permit),
  .speed_change_start_q(speed_change_start_q));
`default_nettype wire

// ==== dv/tb_port_event_and_link_config_regs.sv ====
// testbench: apb register, event, pin, link and interrupt checks of the bank
// assumes a downstream instance and an upstream twin sharing one 100 MHz clock and one bus
`timescale 1ns/10ps
`default_nettype none
module tb_port_event_and_link_config_regs;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, gpio7_out, gpio7_oe_n;
  logic        gpio7_out_normal = 1, gpio7_oe_normal_n = 1, link_in_detect = 0, link_in_l0 = 0, irq, er, im;
  logic        gen2_permissible = 1, upconfigure_capable = 0, low_swing_select, self_loop_permit, speed_change_start_q;
  logic [2:0]  notify_req = 0, native_notify;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [11:0] regs [8] = '{12'h450, 12'h454, 12'h500, 12'h530, 12'h538, 12'h600, 12'h604, 12'h608};
  logic        up_start;
  logic [31:0] up_prdata;
  int          fail_count = 0, n_checks = 0, pulses = 0, up_pulses = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (speed_change_start_q === 1'b1) pulses++;
  always @(posedge clk) if (up_start === 1'b1) up_pulses++;
  port_event_and_link_config_regs #(.NPORTS(3), .IS_UPSTREAM(0)) DUT (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .notify_req(notify_req), .native_notify(native_notify), .gpio7_in(1'b0),
    .gpio7_out_normal(gpio7_out_normal), .gpio7_oe_normal_n(gpio7_oe_normal_n), .gpio7_out(gpio7_out),
    .gpio7_oe_n(gpio7_oe_n), .link_in_detect(link_in_detect), .link_in_l0(link_in_l0),
    .gen2_permissible(gen2_permissible), .upconfigure_capable(upconfigure_capable),
    .low_swing_select(low_swing_select), .self_loop_permit(self_loop_permit),
    .speed_change_start_q(speed_change_start_q), .irq(irq));
  // upstream twin sees every transfer; only its read data and speed pulse are watched
  port_event_and_link_config_regs #(.NPORTS(3), .IS_UPSTREAM(1)) up_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(), .prdata(up_prdata),
    .pslverr(), .notify_req(notify_req), .native_notify(), .gpio7_in(1'b0),
    .gpio7_out_normal(gpio7_out_normal), .gpio7_oe_normal_n(gpio7_oe_normal_n), .gpio7_out(),
    .gpio7_oe_n(), .link_in_detect(link_in_detect), .link_in_l0(link_in_l0),
    .gen2_permissible(gen2_permissible), .upconfigure_capable(upconfigure_capable),
    .low_swing_select(), .self_loop_permit(), .speed_change_start_q(up_start), .irq());
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // request held from setup until pready is seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      fail_count++;
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    #1;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // detect then l0, as the link would enter l0 for the first time
  task automatic link_up;
    @(posedge clk) link_in_detect <= 1;
    repeat (2) @(posedge clk);
    link_in_detect <= 0;
    link_in_l0 <= 1;
    repeat (4) @(posedge clk);
    link_in_l0 <= 0;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    foreach (regs[i]) rdc(regs[i], 32'h0);
    rdc(12'h7fc, 32'h0);
    chk(er, 1'b1);
    xfer(1'b0, 12'h530, 32'h0);
    chk(up_prdata, 32'h4000);
    xfer(1'b1, 12'h500, 32'hffffffff);
    rdc(12'h500, 32'h100);
    chk(low_swing_select, 1'b1);
    link_up();
    chk(pulses, 1);
    chk(up_pulses, 0);
    xfer(1'b1, 12'h530, 32'hffffffff);
    rdc(12'h530, 32'h7000);
    chk(self_loop_permit, 1'b0);
    xfer(1'b1, 12'h530, 32'h6000);
    chk(self_loop_permit, 1'b1);
    link_up();
    chk(pulses, 1);
    @(posedge clk) upconfigure_capable <= 1;
    repeat (2) @(posedge clk);
    rdc(12'h538, 32'h10000);
    xfer(1'b1, 12'h600, 32'h1f);
    rdc(12'h600, 32'h0);
    @(posedge clk) notify_req <= 3'h7;
    #1 chk(native_notify, 3'h7);
    rdc(12'h454, 32'h0);
    xfer(1'b1, 12'h450, 32'h0a);
    chk(native_notify, 3'h2);
    rdc(12'h454, 32'h0a);
    chk({gpio7_oe_n, gpio7_out}, 2'b11);
    xfer(1'b1, 12'h608, 32'h1);
    chk({gpio7_oe_n, gpio7_out}, 2'b00);
    xfer(1'b1, 12'h450, 32'h0b);
    chk({gpio7_oe_n, gpio7_out}, 2'b01);
    rdc(12'h600, 32'h05);
    xfer(1'b1, 12'h604, 32'h0);
    im = irq;
    xfer(1'b1, 12'h604, 32'h1f);
    chk({im, irq}, 32'h1);
    xfer(1'b1, 12'h600, 32'h1f);
    rdc(12'h600, 32'h0);
    chk(irq, 1'b0);
    @(posedge clk) notify_req <= 3'h0;
    rdc(12'h454, 32'h0);
    end_sim();
  end
endmodule // tb_port_event_and_link_config_regs
`default_nettype wire
